/* File: inc/sacc_pkg.sv */
// shared constants and types of the converter control block
package sacc_pkg;
	// bus
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHAN = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [7:0] OFS_MASK = 8'h10;
	// control register fields
	localparam logic [15:0] CTRL_RST = 16'h0600;
	localparam logic [15:0] CTRL_WMASK = 16'h3fbf;
	localparam int unsigned CTRL_TEMP = 13;
	localparam int unsigned CTRL_DIV_LSB = 10;
	localparam int unsigned CTRL_ACQ_LSB = 8;
	localparam int unsigned CTRL_EN = 7;
	localparam int unsigned CTRL_PWR = 5;
	localparam int unsigned CTRL_DIFF = 4;
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam logic [3:0] CHAN_RST = 4'h0;
	localparam logic [3:0] TEMP_CHAN = 4'hf;
	// result and status layout
	localparam int unsigned RES_BITS = 12;
	localparam int unsigned RES_LSB = 16;
	localparam int unsigned STAT_DONE = 0;
	localparam int unsigned STAT_OVR = 1;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	// converter timing, in converter clocks
	localparam logic [4:0] EXTRA_CLKS = 5'h13;
	localparam logic [4:0] TRIAL_CLKS = 5'h0c;
	localparam logic [4:0] FINISH_CLKS = EXTRA_CLKS - TRIAL_CLKS;
	localparam logic [11:0] MID_CODE = 12'h800;
	localparam int unsigned SRC_CLK_HZ = 41780000;
	localparam int unsigned MAX_SPS = 1000000;

	typedef enum logic [2:0] {
		MODE_IDLE = 3'b000,
		MODE_SINGLE = 3'b001,
		MODE_CONT = 3'b010,
		MODE_EXT_PIN = 3'b011,
		MODE_PLA = 3'b100,
		MODE_GENERAL_TIMER_ZERO = 3'b101,
		MODE_GENERAL_TIMER_ONE = 3'b110
	} sacc_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ = 2'b01,
		ST_TRIAL = 2'b10,
		ST_FINISH = 2'b11
	} sacc_state_t;

	// trigger sources, in sync order
	typedef struct packed {
		logic timer_one;
		logic timer_zero;
		logic programmable_logic_array;
		logic ext_pin;
	} sacc_trig_t;

	// drive towards the analog core
	typedef struct packed {
		logic power;
		logic diff;
		logic sample;
		logic [3:0] chan;
		logic [11:0] dac;
	} sacc_ana_t;
endpackage

/* File: design/sacc_sync_edge.sv */
// two-stage synchroniser with rising-edge detect
`timescale 1ns/10ps
module sacc_sync_edge #(
	parameter int unsigned WIDTH = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// asynchronous inputs
	input wire logic [WIDTH-1:0] async_in,
	// synchronised level and one-cycle rise
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] last_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;
	logic [WIDTH-1:0] nxt_last;

	always_comb begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
		nxt_last = sync_ff;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
			last_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			last_ff <= nxt_last;
		end
	end

	assign level = sync_ff;
	assign rise = sync_ff & ~last_ff;
endmodule // sacc_sync_edge

/* File: design/sacc_top.sv */
// successive-approximation converter control with apb registers
// What this block does
// - 12-bit successive approximation, single-ended or differential
// - reaches 1 MSPS at fastest divider setting
// - software single and continuous conversions
// - pin, logic array, timer overflows trigger conversions
// - temperature channel selectable on input multiplexer
// - single-ended results are straight binary
// - differential results twos complement, shifted right one
// - result in bits 27:16, sign above
// - reset: acquire 8, divide 2, 19 extra
`timescale 1ns/10ps
module sacc_top (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sacc_pkg::ADDR_W-1:0] paddr,
	input wire logic [sacc_pkg::DATA_W-1:0] pwdata,
	output logic [sacc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// conversion trigger sources
	input wire sacc_pkg::sacc_trig_t trig_in,
	// analog core
	input wire logic cmp_hi,
	output sacc_pkg::sacc_ana_t ana,
	// interrupt
	output logic irq
);
	// register group
	logic [15:0] ctrl_ff;
	logic [3:0] chan_ff;
	logic [31:0] result_ff;
	logic [1:0] stat_ff;
	logic [1:0] mask_ff;
	logic irq_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic single_go_ff;
	logic cont_go_ff;
	logic [15:0] nxt_ctrl;
	logic [3:0] nxt_chan;
	logic [31:0] nxt_result;
	logic [1:0] nxt_stat;
	logic [1:0] nxt_mask;
	logic nxt_irq;
	logic [31:0] nxt_prdata;
	logic nxt_pready;
	logic nxt_pslverr;
	logic nxt_single_go;
	logic nxt_cont_go;
	// engine group
	sacc_pkg::sacc_state_t state_ff;
	sacc_pkg::sacc_state_t nxt_state;
	logic [4:0] div_cnt_ff;
	logic [4:0] nxt_div_cnt;
	logic [4:0] step_cnt_ff;
	logic [4:0] nxt_step_cnt;
	logic [11:0] bit_ff;
	logic [11:0] nxt_bit;
	logic cont_ff;
	logic nxt_cont;
	logic done_ff;
	logic nxt_done;
	logic [11:0] code_ff;
	logic [11:0] nxt_code;
	sacc_pkg::sacc_ana_t ana_ff;
	sacc_pkg::sacc_ana_t nxt_ana;
	// helpers
	sacc_pkg::sacc_trig_t trig_rise;
	logic access;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic [2:0] mode;
	logic [2:0] div_code;
	logic [4:0] div_max;
	logic [4:0] acq_len;
	logic tick;
	logic hw_trig;
	logic go;
	logic [11:0] tc_code;
	logic [31:0] fmt_result;

	sacc_sync_edge #(
		.WIDTH(4)
	) u_trig_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in(trig_in),
		.level(),
		.rise(trig_rise)
	);

	assign mode = ctrl_ff[sacc_pkg::CTRL_MODE_LSB +: 3];
	assign div_code = ctrl_ff[sacc_pkg::CTRL_DIV_LSB +: 3];
	// codes above /32 are reserved and run at /32
	assign div_max = (div_code > 3'h5) ? 5'h1f : 5'((6'h01 << div_code) - 6'h01);
	assign acq_len = 5'(6'h02 << ctrl_ff[sacc_pkg::CTRL_ACQ_LSB +: 2]);
	// divider /1 gives one bit trial per mclk for top throughput
	assign tick = (div_cnt_ff == div_max);

	// bus decode: one wait state so read data leaves a flop
	assign access = psel && penable && pready_ff;
	assign wr_en = access && pwrite;
	assign rd_en = access && !pwrite;
	assign mapped = (paddr == sacc_pkg::OFS_CTRL) || (paddr == sacc_pkg::OFS_CHAN)
		|| (paddr == sacc_pkg::OFS_RESULT) || (paddr == sacc_pkg::OFS_STAT)
		|| (paddr == sacc_pkg::OFS_MASK);

	always_comb begin
		hw_trig = 1'b0;
		case (mode)
			sacc_pkg::MODE_EXT_PIN: hw_trig = trig_rise.ext_pin;
			sacc_pkg::MODE_PLA: hw_trig = trig_rise.programmable_logic_array;
			sacc_pkg::MODE_GENERAL_TIMER_ZERO: hw_trig = trig_rise.timer_zero;
			sacc_pkg::MODE_GENERAL_TIMER_ONE: hw_trig = trig_rise.timer_one;
			default: hw_trig = 1'b0;
		endcase
	end

	// continuous runs on after enable drops; hardware triggers need enable
	assign go = ctrl_ff[sacc_pkg::CTRL_PWR] && (single_go_ff || cont_ff
		|| (ctrl_ff[sacc_pkg::CTRL_EN] && hw_trig));

	// differential: offset code to twos complement, arithmetic shift right
	assign tc_code = code_ff ^ sacc_pkg::MID_CODE;
	always_comb begin
		fmt_result = '0;
		if (ctrl_ff[sacc_pkg::CTRL_DIFF]) begin
			fmt_result = {{5{tc_code[11]}}, tc_code[11:1], 16'h0000};
		end else begin
			fmt_result = {4'h0, code_ff, 16'h0000};
		end
	end

	// register group next state
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_chan = chan_ff;
		nxt_result = result_ff;
		nxt_stat = stat_ff;
		nxt_mask = mask_ff;
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		nxt_single_go = 1'b0;
		nxt_cont_go = 1'b0;
		nxt_pready = psel && penable && !pready_ff;
		if (nxt_pready) begin
			nxt_pslverr = !mapped;
			case (paddr)
				sacc_pkg::OFS_CTRL: nxt_prdata = {16'h0000, ctrl_ff};
				sacc_pkg::OFS_CHAN: nxt_prdata = {28'h0000000, chan_ff};
				sacc_pkg::OFS_RESULT: nxt_prdata = result_ff;
				sacc_pkg::OFS_STAT: nxt_prdata = {27'h0000000, state_ff != sacc_pkg::ST_IDLE,
					cont_ff, 1'b0, stat_ff};
				sacc_pkg::OFS_MASK: nxt_prdata = {30'h00000000, mask_ff};
				default: nxt_prdata = '0;
			endcase
		end
		if (wr_en) begin
			case (paddr)
				sacc_pkg::OFS_CTRL: begin
					nxt_ctrl = pwdata[15:0] & sacc_pkg::CTRL_WMASK;
					if (pwdata[sacc_pkg::CTRL_EN]) begin
						nxt_single_go = (pwdata[2:0] == sacc_pkg::MODE_SINGLE);
						nxt_cont_go = (pwdata[2:0] == sacc_pkg::MODE_CONT);
					end
				end
				sacc_pkg::OFS_CHAN: nxt_chan = pwdata[3:0];
				sacc_pkg::OFS_STAT: nxt_stat = stat_ff & ~pwdata[1:0];
				sacc_pkg::OFS_MASK: nxt_mask = pwdata[1:0];
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
		if (rd_en && (paddr == sacc_pkg::OFS_RESULT)) begin
			nxt_stat[sacc_pkg::STAT_DONE] = 1'b0;
		end
		// a new result beats a clear in the same cycle
		if (done_ff) begin
			nxt_result = fmt_result;
			nxt_stat[sacc_pkg::STAT_DONE] = 1'b1;
			if (stat_ff[sacc_pkg::STAT_DONE]) begin
				nxt_stat[sacc_pkg::STAT_OVR] = 1'b1;
			end
		end
		nxt_irq = |(nxt_stat & nxt_mask);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_ff <= sacc_pkg::CTRL_RST;
			chan_ff <= sacc_pkg::CHAN_RST;
			result_ff <= '0;
			stat_ff <= sacc_pkg::STAT_RST;
			mask_ff <= sacc_pkg::MASK_RST;
			irq_ff <= 1'b0;
			prdata_ff <= '0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			single_go_ff <= 1'b0;
			cont_go_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			chan_ff <= nxt_chan;
			result_ff <= nxt_result;
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			irq_ff <= nxt_irq;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			single_go_ff <= nxt_single_go;
			cont_go_ff <= nxt_cont_go;
		end
	end

	// conversion engine next state
	always_comb begin
		nxt_state = state_ff;
		nxt_div_cnt = tick ? 5'h00 : div_cnt_ff + 5'h01;
		nxt_step_cnt = step_cnt_ff;
		nxt_bit = bit_ff;
		nxt_code = code_ff;
		nxt_done = 1'b0;
		nxt_cont = cont_ff;
		nxt_ana = ana_ff;
		nxt_ana.power = ctrl_ff[sacc_pkg::CTRL_PWR];
		nxt_ana.diff = ctrl_ff[sacc_pkg::CTRL_DIFF];
		nxt_ana.chan = ctrl_ff[sacc_pkg::CTRL_TEMP] ? sacc_pkg::TEMP_CHAN : chan_ff;
		if (cont_go_ff) begin
			nxt_cont = 1'b1;
		end else if ((mode != sacc_pkg::MODE_CONT) || !ctrl_ff[sacc_pkg::CTRL_PWR]) begin
			nxt_cont = 1'b0;
		end
		case (state_ff)
			sacc_pkg::ST_IDLE: begin
				nxt_ana.sample = 1'b0;
				if (go) begin
					nxt_state = sacc_pkg::ST_ACQ;
					nxt_div_cnt = 5'h00;
					nxt_step_cnt = 5'h00;
					nxt_ana.sample = 1'b1;
				end
			end
			sacc_pkg::ST_ACQ: begin
				if (tick) begin
					nxt_step_cnt = step_cnt_ff + 5'h01;
					if (step_cnt_ff == acq_len - 5'h01) begin
						nxt_state = sacc_pkg::ST_TRIAL;
						nxt_step_cnt = 5'h00;
						nxt_ana.sample = 1'b0;
						nxt_ana.dac = sacc_pkg::MID_CODE;
						nxt_bit = sacc_pkg::MID_CODE;
					end
				end
			end
			sacc_pkg::ST_TRIAL: begin
				// comparator is a clocked latch in this domain, read directly
				if (tick) begin
					nxt_ana.dac = (cmp_hi ? ana_ff.dac : (ana_ff.dac & ~bit_ff)) | (bit_ff >> 1);
					nxt_bit = bit_ff >> 1;
					if (bit_ff[0]) begin
						nxt_code = cmp_hi ? ana_ff.dac : (ana_ff.dac & ~bit_ff);
						nxt_state = sacc_pkg::ST_FINISH;
						nxt_step_cnt = 5'h00;
					end
				end
			end
			sacc_pkg::ST_FINISH: begin
				if (tick) begin
					nxt_step_cnt = step_cnt_ff + 5'h01;
					if (step_cnt_ff == sacc_pkg::FINISH_CLKS - 5'h01) begin
						nxt_done = 1'b1;
						nxt_state = sacc_pkg::ST_IDLE;
					end
				end
			end
			default: nxt_state = sacc_pkg::ST_IDLE;
		endcase
		if (!ctrl_ff[sacc_pkg::CTRL_PWR]) begin
			nxt_state = sacc_pkg::ST_IDLE;
			nxt_ana.sample = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_ff <= sacc_pkg::ST_IDLE;
			div_cnt_ff <= 5'h00;
			step_cnt_ff <= 5'h00;
			bit_ff <= 12'h000;
			code_ff <= 12'h000;
			done_ff <= 1'b0;
			cont_ff <= 1'b0;
			ana_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			div_cnt_ff <= nxt_div_cnt;
			step_cnt_ff <= nxt_step_cnt;
			bit_ff <= nxt_bit;
			code_ff <= nxt_code;
			done_ff <= nxt_done;
			cont_ff <= nxt_cont;
			ana_ff <= nxt_ana;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign ana = ana_ff;
	assign irq = irq_ff;
endmodule // sacc_top

/* File: tb/sacc_top_sva.sv */
// port assertions of the converter control block
`timescale 1ns/10ps
module sacc_top_sva (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sacc_pkg::ADDR_W-1:0] paddr,
	input wire logic [sacc_pkg::DATA_W-1:0] pwdata,
	input wire logic [sacc_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// converter side
	input wire sacc_pkg::sacc_trig_t trig_in,
	input wire logic cmp_hi,
	input wire sacc_pkg::sacc_ana_t ana,
	input wire logic irq
);
	logic acc;
	logic wr_ctl;
	assign acc = psel && penable && pready && !pslverr;
	assign wr_ctl = acc && pwrite && paddr == sacc_pkg::OFS_CTRL;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_rdy_wait;
		psel && !penable |=> !pready ##1 pready;
	endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("pready not after one wait state");
	property p_err_pair;
		pslverr |-> pready;
	endproperty
	a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
	property p_ctl_out;
		wr_ctl |-> ##2 ana.power == $past(pwdata[sacc_pkg::CTRL_PWR], 2)
			&& ana.diff == $past(pwdata[sacc_pkg::CTRL_DIFF], 2);
	endproperty
	a_ctl_out: assert property (p_ctl_out) else $error("power or diff not from control");
	property p_temp;
		wr_ctl && pwdata[sacc_pkg::CTRL_TEMP] |-> ##2 ana.chan == sacc_pkg::TEMP_CHAN;
	endproperty
	a_temp: assert property (p_temp) else $error("temperature channel not selected");
	property p_sample_pwr;
		ana.sample |-> ana.power;
	endproperty
	a_sample_pwr: assert property (p_sample_pwr) else $error("sampling while off");
	property p_dac_mid;
		$fell(ana.sample) |-> ##[0:2] ana.dac == sacc_pkg::MID_CODE;
	endproperty
	a_dac_mid: assert property (p_dac_mid) else $error("first trial not midscale");
	// default timing only: 8 acquire, divide 2, 19 extra
	property p_conv_len;
		$rose(irq) && !$past(pready) |-> $past(ana.sample, 44);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length off");
	property p_res_fmt;
		acc && !pwrite && paddr == sacc_pkg::OFS_RESULT |-> prdata[15:0] == 16'h0000
			&& prdata[31:28] == (ana.diff ? {4{prdata[27]}} : 4'h0);
	endproperty
	a_res_fmt: assert property (p_res_fmt) else $error("result layout wrong");
endmodule // sacc_top_sva

/* File: tb/sacc_core_model.sv */
// behavioural analog core: track and hold plus comparator
`timescale 1ns/10ps
module sacc_core_model #(
	parameter logic [11:0] TEMP_CODE = 12'h3c5
) (
	// clock
	input wire logic mclk,
	// drive from the control block
	input wire sacc_pkg::sacc_ana_t ana,
	// external input as a code
	input wire logic [11:0] vin,
	// comparator
	output logic cmp_hi
);
	logic [11:0] held_ff;
	logic last_ff;
	always_ff @(posedge mclk) begin
		if (ana.sample)
			held_ff <= (ana.chan == sacc_pkg::TEMP_CHAN) ? TEMP_CODE : vin;
		last_ff <= cmp_hi;
	end
	// unpowered comparator gives no steady answer
	assign cmp_hi = ana.power ? (held_ff >= ana.dac) : ~last_ff;
endmodule // sacc_core_model

/* File: tb/sacc_top_tb.sv */
// self-checking bench of the converter control block
`timescale 1ns/10ps
module sacc_top_tb;
	localparam logic [11:0] TEMP_CODE = 12'h3c5;
	localparam logic [73:0] REGS [10] = '{
		{2'b00, 8'h00, 32'h0, 32'h600}, {2'b00, 8'h04, 32'h0, 32'h0},
		{2'b00, 8'h08, 32'h0, 32'h0}, {2'b00, 8'h0c, 32'h0, 32'h0},
		{2'b00, 8'h10, 32'h0, 32'h0}, {2'b01, 8'h00, 32'hc740, 32'h700},
		{2'b01, 8'h04, 32'hfffffff5, 32'h5}, {2'b01, 8'h08, 32'hffffffff, 32'h0},
		{2'b11, 8'h14, 32'hffffffff, 32'h0}, {2'b01, 8'h10, 32'hffffffff, 32'h3}};
	localparam logic [27:0] CONV [8] = '{28'h06a1000, 28'h06a1fff, 28'h06a15a3,
		28'h06b1800, 28'h06b1000, 28'h06b1fff, 28'h06b15a3, 28'h26a1123};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	sacc_pkg::sacc_trig_t trig_in = 4'h0;
	logic cmp_hi;
	sacc_pkg::sacc_ana_t ana;
	logic irq;
	logic [11:0] vin = 12'h000;
	logic [31:0] rd;
	logic er;
	int fails = 0;
	int check_count = 0;
	int n;
	int m;
	always #2 mclk = ~mclk;
	sacc_top i_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .trig_in, .cmp_hi, .ana, .irq);
	sacc_core_model #(.TEMP_CODE(TEMP_CODE)) i_core (.mclk, .ana, .vin, .cmp_hi);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h", $time, s, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(k, k < 50 ? k : 0, "no pready");
	endtask
	task automatic wait_irq(input logic v, input int lim, input string s);
		n = 0;
		while (irq !== v && n < lim) begin
			@(posedge mclk);
			n++;
		end
		chk(irq, v, s);
	endtask
	task automatic wait_smp(input int lim);
		n = 0;
		while (ana.sample !== 1'b1 && n < lim) begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic poll(input int b, input logic v);
		m = 0;
		do begin
			apb(1'b0, sacc_pkg::OFS_STAT, 32'h0);
			m++;
		end while (rd[b] !== v && m < 60);
		chk(rd[b], v, "poll");
	endtask
	function automatic logic [31:0] res_of(input logic d, input logic [11:0] v);
		logic [11:0] c;
		c = v ^ 12'h800;
		if (d)
			return {{5{c[11]}}, c[11:1], 16'h0000};
		return {4'h0, v, 16'h0000};
	endfunction
	task automatic summarize();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		$display("unexpected at %0t: watchdog", $time);
		summarize();
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		foreach (REGS[i]) begin
			if (REGS[i][72])
				apb(1'b1, REGS[i][71:64], REGS[i][63:32]);
			apb(1'b0, REGS[i][71:64], 32'h0);
			chk(rd, REGS[i][31:0], "register");
			chk(er, REGS[i][73], "error flag");
		end
		foreach (CONV[i]) begin
			vin <= CONV[i][11:0];
			apb(1'b1, sacc_pkg::OFS_CTRL, {16'h0, CONV[i][27:12]});
			wait_smp(20);
			chk(ana.chan, CONV[i][25] ? 32'hf : 32'h5, "channel");
			wait_irq(1'b1, 200, "done");
			apb(1'b0, sacc_pkg::OFS_RESULT, 32'h0);
			chk(rd, res_of(CONV[i][16], CONV[i][25] ? TEMP_CODE : CONV[i][11:0]), "result");
			wait_irq(1'b0, 4, "read clear");
		end
		apb(1'b1, sacc_pkg::OFS_MASK, 32'h0);
		apb(1'b1, sacc_pkg::OFS_CTRL, 32'h06a1);
		poll(0, 1'b1);
		chk(irq, 1'b0, "masked");
		apb(1'b1, sacc_pkg::OFS_MASK, 32'h1);
		wait_irq(1'b1, 4, "unmasked");
		apb(1'b1, sacc_pkg::OFS_STAT, 32'h1);
		wait_irq(1'b0, 4, "w1c");
		apb(1'b1, sacc_pkg::OFS_CTRL, 32'h06a2);
		wait_irq(1'b1, 200, "cont");
		apb(1'b1, sacc_pkg::OFS_CTRL, 32'h0622);
		apb(1'b0, sacc_pkg::OFS_RESULT, 32'h0);
		wait_irq(1'b0, 4, "cont read");
		wait_irq(1'b1, 200, "cont on");
		apb(1'b1, sacc_pkg::OFS_CTRL, 32'h0620);
		poll(4, 1'b0);
		apb(1'b0, sacc_pkg::OFS_STAT, 32'h0);
		chk(rd[1:0], 2'h3, "overrun");
		apb(1'b1, sacc_pkg::OFS_STAT, 32'h3);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, sacc_pkg::OFS_CTRL, 32'h0623 + i);
			trig_in <= 4'h1 << i;
			wait_smp(40);
			chk(ana.sample, 1'b0, "start refused");
			trig_in <= 4'h0;
			apb(1'b1, sacc_pkg::OFS_CTRL, 32'h06a3 + i);
			trig_in <= 4'h1 << i;
			wait_smp(20);
			chk(ana.sample, 1'b1, "trigger");
			trig_in <= 4'h0;
			wait_irq(1'b1, 200, "trig done");
			apb(1'b0, sacc_pkg::OFS_RESULT, 32'h0);
			wait_irq(1'b0, 4, "trig read");
		end
		// reset in mid-run with the engine idle and a flag pending
		apb(1'b1, sacc_pkg::OFS_CTRL, 32'h06a1);
		wait_irq(1'b1, 200, "before reset");
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0, "reset irq");
		chk(ana, 32'h0, "reset analog drive");
		rst <= 1'b0;
		apb(1'b0, sacc_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h600, "reset control");
		apb(1'b0, sacc_pkg::OFS_STAT, 32'h0);
		chk(rd, 32'h0, "reset status");
		summarize();
	end
endmodule // sacc_top_tb
bind sacc_top sacc_top_sva i_sva (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .trig_in, .cmp_hi, .ana, .irq);
